// ==== verification/path_term_model.sv ====
// Behavioural path terminator: paces payload slots and loops octets back.
// Assumes the adapter answers every slot exactly one cycle later.
`timescale 1ns/1ps

module path_term_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       corrupt_i,
  output logic            slot_o,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_byte_o
);
  initial begin
    slot_o     = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
  end

  // Half-rate slots keep the receive buffer from filling during long runs
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      slot_o <= 1'b0;
    end else begin
      slot_o <= ~slot_o;
    end
  end

  // Whole octets go back in order; corruption inverts each of them
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_byte_o  <= 8'h00;
    end else if (tx_valid_i) begin
      rx_valid_o <= 1'b1;
      rx_byte_o  <= corrupt_i ? ~tx_byte_i : tx_byte_i;
    end else begin
      rx_valid_o <= 1'b0;
      // Between strobes the lane must not keep showing the last octet
      rx_byte_o  <= ~rx_byte_o;
    end
  end
endmodule : path_term_model

// ==== verification/tb_atm_cell_pdh_path_adapter.sv ====
// Self-checking bench: loopback through a path terminator model.
// Assumes 53-octet cells, two-cycle slot spacing and the default VPI table.
`timescale 1ns/1ps

module tb_atm_cell_pdh_path_adapter;
  localparam int CELL_CYC = 106;

  logic                   ref_clk_i          = 1'b0;
  logic                   rst_i              = 1'b1;
  logic                   monitored_state_i  = 1'b1;
  logic                   hec_correct_en_i   = 1'b1;
  logic                   hec_pass_invalid_i = 1'b0;
  logic                   vpi_wr_i           = 1'b0;
  logic [1:0]             vpi_wr_idx_i       = 2'h0;
  logic [7:0]             vpi_wr_val_i       = 8'h00;
  logic [3:0]             tx_flow_valid_i    = 4'h0;
  logic                   rx_ready_i         = 1'b1;
  logic                   corrupt            = 1'b0;
  logic [3:0][7:0]        cnt                = '0;
  logic [3:0][7:0]        tx_flow_data_i;
  logic                   monitored_state_o;
  logic [3:0]             tx_flow_ready_o;
  logic                   path_tx_slot_i;
  logic [7:0]             path_tx_byte_o;
  logic                   path_tx_valid_o;
  logic                   path_rx_valid_i;
  logic [7:0]             path_rx_byte_i;
  logic                   rx_valid_o;
  vp_mux_pkg::cell_byte_s rx_cell_o;
  logic                   rx_buf_ready_o;
  logic                   rx_drop_o;
  logic                   cell_delineation_loss_o;
  int                     err_count  = 0;
  int                     num_checks = 0;
  int                     ndrop      = 0;
  int                     nrx[4]     = '{0, 0, 0, 0};
  logic [7:0]             tx_q[$];

  assign tx_flow_data_i = cnt;

  always #2.5 ref_clk_i = ~ref_clk_i;

  atm_cell_pdh_path_adapter dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .monitored_state_i(monitored_state_i),
    .monitored_state_o(monitored_state_o),
    .hec_correct_en_i(hec_correct_en_i),
    .hec_pass_invalid_i(hec_pass_invalid_i),
    .vpi_wr_i(vpi_wr_i), .vpi_wr_idx_i(vpi_wr_idx_i),
    .vpi_wr_val_i(vpi_wr_val_i),
    .tx_flow_valid_i(tx_flow_valid_i), .tx_flow_data_i(tx_flow_data_i),
    .tx_flow_ready_o(tx_flow_ready_o), .path_tx_slot_i(path_tx_slot_i),
    .path_tx_byte_o(path_tx_byte_o), .path_tx_valid_o(path_tx_valid_o),
    .path_rx_valid_i(path_rx_valid_i), .path_rx_byte_i(path_rx_byte_i),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .rx_cell_o(rx_cell_o), .rx_buf_ready_o(rx_buf_ready_o),
    .rx_drop_o(rx_drop_o),
    .cell_delineation_loss_o(cell_delineation_loss_o)
  );

  path_term_model partner (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .corrupt_i(corrupt),
    .slot_o(path_tx_slot_i), .tx_byte_i(path_tx_byte_o),
    .tx_valid_i(path_tx_valid_o), .rx_valid_o(path_rx_valid_i),
    .rx_byte_o(path_rx_byte_i)
  );

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // Reference header check octet, written independently of the design
  function automatic logic [7:0] ref_hec(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    end
    return c ^ 8'h55;
  endfunction : ref_hec

  task automatic cells(input int n);
    repeat (n * CELL_CYC) @(posedge ref_clk_i);
  endtask : cells

  // Each flow sends a counting pattern, so order and loss both show
  task automatic rx_check(input vp_mux_pkg::cell_byte_s c);
    int i;
    chk(c.flow === 2'h0 || c.flow === 2'h1, "flow index");
    i = nrx[c.flow];
    if (i < 96) begin
      chk(c.data === i[7:0], "payload octet");
      chk(c.sop === (i % 48 == 0), "start of cell flag");
    end
    nrx[c.flow] = i + 1;
  endtask : rx_check

  task automatic tx_check;
    logic [31:0] h;
    int          users;
    users = 0;
    for (int k = 0; 53 * k + 4 < tx_q.size(); k++) begin
      h = {tx_q[53*k], tx_q[53*k+1], tx_q[53*k+2], tx_q[53*k+3]};
      chk(tx_q[53*k+4] === ref_hec(h), "header check octet");
      if (h === 32'h01100200 || h === 32'h01200200) begin
        users++;
      end else begin
        chk(h === 32'h00000001, "idle or user header");
      end
    end
    chk(tx_q[4] === 8'h52, "idle check octet");
    chk(users >= 4, "user cells sent");
  endtask : tx_check

  always @(posedge ref_clk_i) begin
    if (path_tx_valid_o === 1'b1) begin
      tx_q.push_back(path_tx_byte_o);
    end
    for (int f = 0; f < 4; f++) begin
      if (tx_flow_ready_o[f] === 1'b1) begin
        cnt[f] <= cnt[f] + 8'h01;
      end
    end
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
      rx_check(rx_cell_o);
    end
    if (rx_drop_o === 1'b1) begin
      ndrop++;
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    finish_test();
  end

  initial begin
    int n0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk(cell_delineation_loss_o === 1'b1, "loss after reset");
    chk(monitored_state_o === 1'b1, "monitor copy");
    // A zero VPI must be refused, so entry 1 keeps 12h
    vpi_wr_idx_i <= 2'h1;
    vpi_wr_i     <= 1'b1;
    @(posedge ref_clk_i);
    vpi_wr_i     <= 1'b0;
    cells(10);
    chk(cell_delineation_loss_o === 1'b0, "delineation found");
    chk(nrx.sum() == 0, "idle cells removed");
    tx_flow_valid_i <= 4'h3;
    for (int n = 0; n < 3000 && !(cnt[0] >= 100 && cnt[1] >= 100); n++) begin
      @(posedge ref_clk_i);
    end
    tx_flow_valid_i <= 4'h0;
    cells(3);
    chk(nrx[0] >= 96 && nrx[1] >= 96, "both flows delivered");
    tx_check();
    n0 = nrx.sum();
    // User cells keep flowing so the discard checks have something to drop
    tx_flow_valid_i <= 4'h3;
    corrupt <= 1'b1;
    cells(10);
    chk(cell_delineation_loss_o === 1'b1, "delineation lost");
    chk(nrx.sum() == n0, "nothing delivered");
    monitored_state_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(cell_delineation_loss_o === 1'b0, "quiet when off");
    chk(monitored_state_o === 1'b0, "monitor copy off");
    monitored_state_i <= 1'b1;
    corrupt <= 1'b0;
    cells(10);
    chk(cell_delineation_loss_o === 1'b0, "delineation regained");
    chk(ndrop == 0, "no octets dropped");
    // A stalled reader fills the buffer; the path cannot wait, so octets go
    rx_ready_i <= 1'b0;
    cells(2);
    chk(rx_buf_ready_o === 1'b0 && ndrop > 0, "overflow drops octets");
    finish_test();
  end
endmodule : tb_atm_cell_pdh_path_adapter

// ==== verilog/atm_cell_pdh_path_adapter.sv ====
// Cell/path adapter: VP mux, idle fill, HEC, scrambling and delineation.
// Assumes octet-aligned path payload strobed at byte rate on ref_clk_i.
`timescale 1ns/1ps

module cell_byte_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cell_byte_fifo

module atm_cell_pdh_path_adapter (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    monitored_state_i,
  output logic                         monitored_state_o,
  input  wire logic                    hec_correct_en_i,
  input  wire logic                    hec_pass_invalid_i,
  input  wire logic                    vpi_wr_i,
  input  wire logic [1:0]              vpi_wr_idx_i,
  input  wire logic [7:0]              vpi_wr_val_i,
  input  wire logic [3:0]              tx_flow_valid_i,
  input  wire logic [3:0][7:0]         tx_flow_data_i,
  output logic      [3:0]              tx_flow_ready_o,
  input  wire logic                    path_tx_slot_i,
  output logic      [7:0]              path_tx_byte_o,
  output logic                         path_tx_valid_o,
  input  wire logic                    path_rx_valid_i,
  input  wire logic [7:0]              path_rx_byte_i,
  output logic                         rx_valid_o,
  input  wire logic                    rx_ready_i,
  output vp_mux_pkg::cell_byte_s       rx_cell_o,
  output logic                         rx_buf_ready_o,
  output logic                         rx_drop_o,
  output logic                         cell_delineation_loss_o
);
  localparam int NF = vp_mux_pkg::NUM_FLOWS;
  localparam int FW = vp_mux_pkg::FLOW_W;
  localparam int SL = vp_mux_pkg::SCR_LEN;

  logic [7:0]    vpi_tab_reg [NF];
  logic [FW-1:0] last_grant_reg;

  // VPI table, default 11h upward; a write of 00h is ignored
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NF; i++) begin
        vpi_tab_reg[i] <= vp_mux_pkg::VPI_BASE + 8'(i);
      end
    end else if (vpi_wr_i && vpi_wr_val_i != vp_mux_pkg::VPI_NONE) begin
      vpi_tab_reg[vpi_wr_idx_i] <= vpi_wr_val_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      monitored_state_o <= 1'b0;
    end else begin
      monitored_state_o <= monitored_state_i;
    end
  end

  // ---------------- Transmit ----------------
  logic [5:0]    tx_pos_reg;
  logic          tx_user_reg;
  logic [FW-1:0] tx_sel_reg;
  logic [31:0]   tx_hdr_reg;
  logic [SL-1:0] tx_scr_reg;
  logic          pick_found;
  logic [FW-1:0] pick_idx;
  logic [31:0]   hdr_new;
  logic [31:0]   hdr_cur;
  logic [7:0]    pay_raw;
  vp_mux_pkg::scr_s tx_scr;
  logic [7:0]    tx_byte;
  logic          at_first;
  logic          in_pay;

  // Round robin starting after the last granted flow
  always_comb begin
    logic [FW-1:0] idx;
    idx        = '0;
    pick_found = 1'b0;
    pick_idx   = '0;
    for (int k = 1; k <= NF; k++) begin
      idx = last_grant_reg + FW'(k);
      if (!pick_found && tx_flow_valid_i[idx]) begin
        pick_found = 1'b1;
        pick_idx   = idx;
      end
    end
  end

  assign at_first = (tx_pos_reg == vp_mux_pkg::POS_FIRST);
  assign in_pay   = (tx_pos_reg >= vp_mux_pkg::POS_PAY);
  assign hdr_new  = pick_found ?
                    {vp_mux_pkg::GFC_TX, vpi_tab_reg[pick_idx],
                     vp_mux_pkg::VCI_TX, vp_mux_pkg::PT_TX,
                     vp_mux_pkg::CLP_TX} :
                    vp_mux_pkg::IDLE_HDR;
  assign hdr_cur  = at_first ? hdr_new : tx_hdr_reg;
  // A flow that stalls mid-cell is padded with the idle fill octet
  assign pay_raw  = (tx_user_reg && tx_flow_valid_i[tx_sel_reg]) ?
                    tx_flow_data_i[tx_sel_reg] : vp_mux_pkg::IDLE_FILL;
  assign tx_scr   = vp_mux_pkg::scr_byte(tx_scr_reg, pay_raw, 1'b0);

  always_comb begin
    case (tx_pos_reg)
      6'h00:   tx_byte = hdr_cur[31:24];
      6'h01:   tx_byte = hdr_cur[23:16];
      6'h02:   tx_byte = hdr_cur[15:8];
      6'h03:   tx_byte = hdr_cur[7:0];
      6'h04:   tx_byte = vp_mux_pkg::hec_calc(hdr_cur);
      default: tx_byte = tx_scr.d;
    endcase
  end

  always_comb begin
    tx_flow_ready_o = '0;
    if (path_tx_slot_i && in_pay && tx_user_reg) begin
      tx_flow_ready_o[tx_sel_reg] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_pos_reg     <= vp_mux_pkg::POS_FIRST;
      tx_user_reg    <= 1'b0;
      tx_sel_reg     <= '0;
      tx_hdr_reg     <= '0;
      last_grant_reg <= FW'(NF-1);
    end else if (path_tx_slot_i) begin
      // One cell per 53 consecutive payload octets
      tx_pos_reg <= (tx_pos_reg == vp_mux_pkg::POS_LAST) ?
                    vp_mux_pkg::POS_FIRST : tx_pos_reg + 6'h01;
      if (at_first) begin
        tx_hdr_reg  <= hdr_new;
        tx_user_reg <= pick_found;
        tx_sel_reg  <= pick_idx;
        if (pick_found) begin
          last_grant_reg <= pick_idx;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_scr_reg <= '0;
    end else if (path_tx_slot_i && in_pay) begin
      tx_scr_reg <= tx_scr.st;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      path_tx_byte_o  <= 8'h00;
      path_tx_valid_o <= 1'b0;
    end else begin
      path_tx_valid_o <= path_tx_slot_i;
      if (path_tx_slot_i) begin
        path_tx_byte_o <= tx_byte;
      end
    end
  end

  // ---------------- Receive ----------------
  vp_mux_pkg::delin_state_e rx_st_reg;
  logic [31:0]   rx_win_reg;
  logic [5:0]    rx_pos_reg;
  logic [2:0]    rx_run_reg;
  logic [SL-1:0] rx_scr_reg;
  logic          rx_acc_reg;
  logic          rx_sop_reg;
  logic [FW-1:0] rx_flow_reg;
  logic          hec_match;
  logic          at_hec;
  vp_mux_pkg::hec_chk_s chk;
  vp_mux_pkg::scr_s     rx_scr;
  logic          vpi_hit;
  logic [FW-1:0] vpi_idx;
  logic          hdr_idle;
  logic          hdr_bad;
  logic          accept;
  vp_mux_pkg::cell_byte_s push_data;
  logic          push;
  logic          buf_ready;

  assign hec_match = (vp_mux_pkg::hec_calc(rx_win_reg) == path_rx_byte_i);
  assign at_hec    = (rx_pos_reg == vp_mux_pkg::POS_HEC);
  assign chk       = vp_mux_pkg::hec_check({rx_win_reg, path_rx_byte_i},
                                           hec_correct_en_i);
  assign rx_scr    = vp_mux_pkg::scr_byte(rx_scr_reg, path_rx_byte_i,
                                          1'b1);

  // Idle cells must match the whole header; the other checks examine only VPI, VCI and CLP
  assign hdr_idle = (chk.hdr == vp_mux_pkg::IDLE_HDR);
  assign hdr_bad  = (chk.hdr[31-4:0] ==
                     {vp_mux_pkg::IDLE_HDR[27:4],
                      chk.hdr[3:1], 1'b1});

  always_comb begin
    vpi_hit = 1'b0;
    vpi_idx = '0;
    for (int i = 0; i < NF; i++) begin
      if (!vpi_hit && chk.hdr[vp_mux_pkg::HDR_VPI_LSB +: 8] ==
          vpi_tab_reg[i]) begin
        vpi_hit = 1'b1;
        vpi_idx = FW'(i);
      end
    end
  end

  assign accept = (rx_st_reg == vp_mux_pkg::ST_SYNC) &&
                  (chk.ok || chk.fixed || hec_pass_invalid_i) &&
                  !hdr_idle && !hdr_bad && vpi_hit;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_win_reg <= '0;
    end else if (path_rx_valid_i) begin
      rx_win_reg <= {rx_win_reg[23:0], path_rx_byte_i};
    end
  end

  // Octet-aligned HEC delineation: hunt, presync, sync
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_st_reg  <= vp_mux_pkg::ST_HUNT;
      rx_pos_reg <= vp_mux_pkg::POS_FIRST;
      rx_run_reg <= 3'h0;
    end else if (path_rx_valid_i) begin
      rx_pos_reg <= (rx_pos_reg == vp_mux_pkg::POS_LAST) ?
                    vp_mux_pkg::POS_FIRST : rx_pos_reg + 6'h01;
      case (rx_st_reg)
        vp_mux_pkg::ST_HUNT: begin
          if (hec_match) begin
            rx_st_reg  <= vp_mux_pkg::ST_PRESYNC;
            rx_pos_reg <= vp_mux_pkg::POS_PAY;
            rx_run_reg <= 3'h1;
          end
        end
        vp_mux_pkg::ST_PRESYNC: begin
          if (at_hec && !hec_match) begin
            rx_st_reg <= vp_mux_pkg::ST_HUNT;
          end else if (at_hec) begin
            rx_run_reg <= rx_run_reg + 3'h1;
            if (rx_run_reg + 3'h1 == vp_mux_pkg::GOOD_LIMIT) begin
              rx_st_reg  <= vp_mux_pkg::ST_SYNC;
              rx_run_reg <= 3'h0;
            end
          end
        end
        vp_mux_pkg::ST_SYNC: begin
          if (at_hec && hec_match) begin
            rx_run_reg <= 3'h0;
          end else if (at_hec) begin
            rx_run_reg <= rx_run_reg + 3'h1;
            if (rx_run_reg + 3'h1 == vp_mux_pkg::BAD_LIMIT) begin
              rx_st_reg <= vp_mux_pkg::ST_HUNT;
            end
          end
        end
        default: rx_st_reg <= vp_mux_pkg::ST_HUNT;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_scr_reg <= '0;
    end else if (path_rx_valid_i && rx_pos_reg >= vp_mux_pkg::POS_PAY) begin
      rx_scr_reg <= rx_scr.st;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_acc_reg  <= 1'b0;
      rx_sop_reg  <= 1'b0;
      rx_flow_reg <= '0;
    end else if (path_rx_valid_i) begin
      if (at_hec) begin
        rx_acc_reg  <= accept;
        rx_sop_reg  <= 1'b1;
        rx_flow_reg <= vpi_idx;
      end else if (push) begin
        rx_sop_reg <= 1'b0;
      end
      if (rx_st_reg != vp_mux_pkg::ST_SYNC) begin
        rx_acc_reg <= 1'b0;
      end
    end
  end

  assign push = path_rx_valid_i && rx_acc_reg &&
                (rx_pos_reg >= vp_mux_pkg::POS_PAY) &&
                (rx_st_reg == vp_mux_pkg::ST_SYNC);
  assign push_data = '{sop: rx_sop_reg, flow: rx_flow_reg, data: rx_scr.d};
  assign rx_buf_ready_o = buf_ready;

  cell_byte_fifo #(
    .WIDTH ($bits(vp_mux_pkg::cell_byte_s)),
    .DEPTH (vp_mux_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   (push_data),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_cell_o)
  );

  // The path cannot be stalled, so a full buffer loses the octet
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_drop_o               <= 1'b0;
      cell_delineation_loss_o <= 1'b0;
    end else begin
      rx_drop_o               <= push && !buf_ready;
      cell_delineation_loss_o <= monitored_state_i &&
                                 (rx_st_reg != vp_mux_pkg::ST_SYNC);
    end
  end

  // ---------------- Checks ----------------
  logic [5:0]  chk_pos_reg;
  logic        chk_user_reg;
  logic [31:0] chk_hist_reg;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      chk_pos_reg  <= '0;
      chk_user_reg <= 1'b0;
      chk_hist_reg <= '0;
    end else if (path_tx_slot_i) begin
      chk_pos_reg  <= tx_pos_reg;
      chk_user_reg <= at_first ? pick_found : tx_user_reg;
      chk_hist_reg <= {chk_hist_reg[23:0], tx_byte};
    end
  end

  a_tx_clp_pt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    path_tx_valid_o && chk_user_reg && chk_pos_reg == 6'h03 |->
    path_tx_byte_o[3:0] == 4'h0) else $error("user cell PT/CLP not zero");
  a_tx_gfc_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    path_tx_valid_o && chk_pos_reg == 6'h00 |->
    path_tx_byte_o[7:4] == 4'h0) else $error("GFC not zero");
  a_tx_pt_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    path_tx_valid_o && chk_pos_reg == 6'h03 |->
    path_tx_byte_o[3:1] == 3'h0) else $error("PT not zero");
  a_tx_idle_hdr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    path_tx_valid_o && !chk_user_reg && chk_pos_reg == 6'h03 |->
    path_tx_byte_o == 8'h01 && chk_hist_reg[31:8] == 24'h000000)
    else $error("idle header wrong");
  a_tx_hec_value: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    path_tx_slot_i && tx_pos_reg == 6'h04 |=>
    path_tx_byte_o == vp_mux_pkg::hec_calc($past(chk_hist_reg)))
    else $error("HEC octet wrong");
  a_hunt_lock: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rx_st_reg == vp_mux_pkg::ST_HUNT && path_rx_valid_i && hec_match |=>
    rx_st_reg == vp_mux_pkg::ST_PRESYNC && rx_pos_reg == 6'h05)
    else $error("hunt did not lock");
  a_sync_loss: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rx_st_reg == vp_mux_pkg::ST_SYNC && path_rx_valid_i && at_hec &&
    !hec_match && rx_run_reg == 3'h6 |=> rx_st_reg == vp_mux_pkg::ST_HUNT)
    else $error("no loss after 7 bad HECs");
  a_lcd_report: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cell_delineation_loss_o |-> $past(monitored_state_i))
    else $error("loss reported while unmonitored");
  a_no_deliver: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    push |-> !cell_delineation_loss_o)
    else $error("cell delivered while lost");
endmodule : atm_cell_pdh_path_adapter

// ==== verilog/vp_mux_pkg.sv ====
// Constants, types and shared functions of the cell/path adapter.
// Assumes one byte-rate clock; the path side strobes each payload octet.
package vp_mux_pkg;
  localparam int          NUM_FLOWS  = 4;
  localparam int          FLOW_W     = 2;
  localparam int          POS_W      = 6;
  localparam logic [5:0]  POS_FIRST  = 6'h00;
  localparam logic [5:0]  POS_HEC    = 6'h04;
  localparam logic [5:0]  POS_PAY    = 6'h05;
  localparam logic [5:0]  POS_LAST   = 6'h34;
  localparam int          HDR_VPI_LSB = 20;
  localparam int          HDR_VCI_LSB = 4;
  localparam int          HDR_PT_LSB  = 1;
  localparam logic [3:0]  GFC_TX     = 4'h0;
  localparam logic [2:0]  PT_TX      = 3'h0;
  localparam logic        CLP_TX     = 1'h0;
  localparam logic [15:0] VCI_TX     = 16'h0020;
  localparam logic [31:0] IDLE_HDR   = 32'h00000001;
  localparam logic [7:0]  IDLE_FILL  = 8'h6A;
  localparam logic [7:0]  HEC_COSET  = 8'h55;
  localparam logic [7:0]  HEC_POLY   = 8'h07;
  localparam logic [7:0]  VPI_BASE   = 8'h11;
  localparam logic [7:0]  VPI_NONE   = 8'h00;
  localparam int          SCR_LEN    = 43;
  localparam logic [2:0]  BAD_LIMIT  = 3'h7;
  localparam logic [2:0]  GOOD_LIMIT = 3'h6;
  localparam int          FIFO_DEPTH = 32;

  typedef enum logic [1:0] {ST_HUNT, ST_PRESYNC, ST_SYNC} delin_state_e;

  typedef struct packed {
    logic              sop;
    logic [FLOW_W-1:0] flow;
    logic [7:0]        data;
  } cell_byte_s;

  typedef struct packed {
    logic [SCR_LEN-1:0] st;
    logic [7:0]         d;
  } scr_s;

  typedef struct packed {
    logic        ok;
    logic        fixed;
    logic [31:0] hdr;
  } hec_chk_s;

  function automatic logic [7:0] hec_calc(input logic [31:0] h);
    logic [7:0] crc;
    logic       fb;
    crc = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      fb  = crc[7] ^ h[i];
      crc = {crc[6:0], 1'b0} ^ (fb ? HEC_POLY : 8'h00);
    end
    return crc ^ HEC_COSET;
  endfunction : hec_calc

  // Self-synchronising: the shift register always takes line-side bits
  function automatic scr_s scr_byte(input logic [SCR_LEN-1:0] st,
                                    input logic [7:0] d,
                                    input logic desc);
    scr_s r;
    r.st = st;
    r.d  = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      r.d[i] = d[i] ^ r.st[SCR_LEN-1];
      r.st   = {r.st[SCR_LEN-2:0], desc ? d[i] : r.d[i]};
    end
    return r;
  endfunction : scr_byte

  // Single-bit correction searches all 40 header bit positions
  function automatic hec_chk_s hec_check(input logic [39:0] h,
                                         input logic fix_en);
    hec_chk_s   r;
    logic [39:0] t;
    r.ok    = (hec_calc(h[39:8]) == h[7:0]);
    r.fixed = 1'b0;
    r.hdr   = h[39:8];
    if (!r.ok && fix_en) begin
      for (int i = 0; i < 40; i++) begin
        t = h ^ (40'h1 << i);
        if (!r.fixed && hec_calc(t[39:8]) == t[7:0]) begin
          r.fixed = 1'b1;
          r.hdr   = t[39:8];
        end
      end
    end
    return r;
  endfunction : hec_check
endpackage : vp_mux_pkg
